// [verilog/qcr_defines.svh]
// constants for the quad continuous read control block
// Behaviour
// - parameter dword top byte reads all ones
// - bit 23 reads zero: no hold/protect disable
// - quad enable is status two bit one
// - write status 01h sets/clears quad enable
// - mode bits A5h with quad enable enter continuous
// - mode bits 00h leave continuous after read
// - eight clocks of Fh leave continuous mode
// - exit-method field bits 15:10 read 111101
// - bit 9 reads one: continuous quad read
// - bits 8:0 read zero: no all-quad mode
`ifndef QCR_DEFINES_SVH
`define QCR_DEFINES_SVH

// register byte offsets on the bus
`define QCR_OFF_SFDP 4'h0
`define QCR_OFF_STAT 4'h4
`define QCR_OFF_CTRL 4'h8
`define QCR_CTRL_RST 1'b1

// parameter dword fields, high to low
`define QCR_RFU_TOP 8'hff
`define QCR_HOLD_WP_DIS 1'b0
`define QCR_QE_REQ 3'h5
`define QCR_ENTRY_METH 4'h9
`define QCR_EXIT_METH 6'h3d
`define QCR_QREAD_SUP 1'b1
`define QCR_QPI_DIS 9'h000

// instructions
`define QCR_CMD_RDSR1 8'h05
`define QCR_CMD_RDSR2 8'h35
`define QCR_CMD_WRSR 8'h01
`define QCR_CMD_QIOR 8'heb

// mode byte values and the all-ones reset
`define QCR_MODE_ENTER 8'ha5
`define QCR_MODE_EXIT 8'h00
`define QCR_NIB_ONES 4'hf
`define QCR_ONES_CLKS 4'h8
`define QCR_ONES_DEAD 4'hf

// status register layout
`define QCR_QE_POS 1
`define QCR_SR1_VAL 8'h00
`define QCR_SR2_BASE 8'h00

// last count value of each link phase
`define QCR_CMD_LAST 5'h07
`define QCR_WSR_LAST 5'h0f
`define QCR_ADDR_LAST 5'h05
`define QCR_MODE_LAST 5'h01
`define QCR_DUMMY_LAST 5'h03

`endif

// [verilog/qcr_pkg.sv]
// types shared by the quad continuous read control block
package qcr_pkg;
   // one nibble on the four data lines
   typedef logic [3:0] qcr_nib_t;
   // link-side frame state
   typedef enum logic [3:0] {
      ST_FIRST, ST_CMD, ST_WSR, ST_RDSR, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGN
   } qcr_state_t;
endpackage

// [verilog/qcr_sync.sv]
// two-flop level synchroniser with asynchronous reset to a constant
module qcr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_r; // first stage, read only by second
   logic [WIDTH-1:0] hold_r; // second stage

   // only levels pass here; events would need a toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= RST_VAL;
         hold_r <= RST_VAL;
      end else begin
         meta_r <= din;
         hold_r <= meta_r;
      end
   end

   assign dout = hold_r;
endmodule

// [verilog/qcr_top.sv]
// quad-enable and continuous quad read control with register slave
`include "qcr_defines.svh"
module qcr_top #(
   parameter int ADDR_W = 4
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0] avsByteenable,
   output logic [31:0] avsReaddata,
   output logic avsWaitrequest,
   input wire logic linkClk,
   input wire logic linkCsN,
   input wire qcr_pkg::qcr_nib_t linkDqIn,
   output qcr_pkg::qcr_nib_t linkDqOut,
   output qcr_pkg::qcr_nib_t linkDqOe
);
   import qcr_pkg::*;

   // register selects
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_SFDP = 2'h1;
   localparam logic [1:0] SEL_STAT = 2'h2;
   localparam logic [1:0] SEL_CTRL = 2'h3;

   // advertised parameter dword, built field by field
   // fixed dword fields
   localparam logic [31:0] SFDP_WORD = {`QCR_RFU_TOP, `QCR_HOLD_WP_DIS, `QCR_QE_REQ,
      `QCR_ENTRY_METH, `QCR_EXIT_METH, `QCR_QREAD_SUP, `QCR_QPI_DIS};

   // address decode shared by read and write paths
   function automatic logic [1:0] regSel(input logic [ADDR_W-1:0] a);
      logic [3:0] lo;
      lo = a[3:0];
      case (lo)
         `QCR_OFF_SFDP: regSel = SEL_SFDP;
         `QCR_OFF_STAT: regSel = SEL_STAT;
         `QCR_OFF_CTRL: regSel = SEL_CTRL;
         default: regSel = SEL_NONE;
      endcase
      if (a != ADDR_W'(lo)) begin
         regSel = SEL_NONE;
      end
   endfunction

   // ---------------- bus side, ref_clk ----------------
   logic wait_r, wait_nxt; // waitrequest, high when idle
   logic [31:0] rd_r, rd_nxt; // read data
   logic ctrlEn_r, ctrlEn_nxt; // link enable control bit
   logic rstLink_r; // registered reset for the link domain
   logic qeS, contS; // link flags seen on ref_clk
   logic [31:0] readMux; // selected read value
   logic req; // any request

   assign req = avsRead | avsWrite;

   // read value mux
   always_comb begin
      case (regSel(avsAddress))
         SEL_SFDP: readMux = SFDP_WORD;
         SEL_STAT: readMux = {30'h0, contS, qeS};
         SEL_CTRL: readMux = {31'h0, ctrlEn_r};
         default: readMux = 32'h0; // unmapped reads zero
      endcase
   end

   // one wait cycle, then completion; writes land at the completion edge
   always_comb begin
      wait_nxt = wait_r;
      rd_nxt = rd_r;
      ctrlEn_nxt = ctrlEn_r;
      if (req && wait_r) begin
         // accept: drop waitrequest, present data
         wait_nxt = 1'b0;
         rd_nxt = readMux;
      end else if (req) begin
         // completion edge: master samples waitrequest low here
         wait_nxt = 1'b1;
         if (avsWrite && regSel(avsAddress) == SEL_CTRL && avsByteenable[0]) begin
            ctrlEn_nxt = avsWritedata[0];
         end
      end
   end

   // bus registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wait_r <= 1'b1;
         rd_r <= 32'h0;
         ctrlEn_r <= `QCR_CTRL_RST;
         rstLink_r <= 1'b1;
      end else begin
         wait_r <= wait_nxt;
         rd_r <= rd_nxt;
         ctrlEn_r <= ctrlEn_nxt;
         rstLink_r <= 1'b0;
      end
   end

   assign avsReaddata = rd_r;
   assign avsWaitrequest = wait_r;

   // ---------------- link side, linkClk ----------------
   logic frameRst; // chip select high or block reset
   logic linkEnS; // link enable seen on linkClk
   qcr_state_t st_r, st_nxt; // frame state
   logic [4:0] cnt_r, cnt_nxt; // bit or nibble count in phase
   logic [15:0] sh_r, sh_nxt; // input/output shifter
   logic [7:0] dat_r, dat_nxt; // address low byte, then data
   logic [3:0] ones_r, ones_nxt; // run of all-ones nibbles
   qcr_nib_t out_r, out_nxt; // data line drive values
   qcr_nib_t oe_r, oe_nxt; // data line enables
   logic qe_r, qe_nxt; // quad_enable_flag, survives frames
   logic cont_r, cont_nxt; // continuous mode, survives frames
   logic [7:0] cmdByte; // instruction completing this edge
   logic [7:0] modeByte; // mode byte completing this edge
   logic [7:0] srByte; // status byte to shift out

   // link flags into ref_clk domain
   qcr_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_stSync (
      .clk(ref_clk),
      .rst(reset),
      .din({cont_r, qe_r}),
      .dout({contS, qeS})
   );

   // chip select ends a frame without needing a link edge
   assign frameRst = linkCsN | rstLink_r;

   qcr_sync #(.WIDTH(1), .RST_VAL(`QCR_CTRL_RST)) u_enSync (
      .clk(linkClk),
      .rst(rstLink_r),
      .din(ctrlEn_r),
      .dout(linkEnS)
   );

   assign cmdByte = {sh_r[6:0], linkDqIn[0]};
   assign modeByte = {sh_r[3:0], linkDqIn};

   // status byte for the instruction just received
   // flag placed at status two bit one
   always_comb begin
      srByte = `QCR_SR2_BASE;
      srByte[`QCR_QE_POS] = qe_r;
      if (cmdByte == `QCR_CMD_RDSR1) begin
         srByte = `QCR_SR1_VAL;
      end
   end

   // frame sequencer; outputs change after the rising edge, host samples next rise
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = 5'(cnt_r + 5'h01);
      sh_nxt = sh_r;
      dat_nxt = dat_r;
      ones_nxt = ones_r;
      out_nxt = out_r;
      oe_nxt = oe_r;
      qe_nxt = qe_r;
      cont_nxt = cont_r;
      case (st_r)
         ST_FIRST: begin
            if (!linkEnS) begin
               // disabled: frame ignored
               st_nxt = ST_IGN;
            end else if (cont_r) begin
               st_nxt = ST_ADDR;
               dat_nxt = {dat_r[3:0], linkDqIn};
            end else begin
               st_nxt = ST_CMD;
               sh_nxt = {sh_r[14:0], linkDqIn[0]};
            end
         end
         ST_CMD: begin
            sh_nxt = {sh_r[14:0], linkDqIn[0]};
            if (cnt_r == `QCR_CMD_LAST) begin
               cnt_nxt = 5'h00;
               case (cmdByte)
                  `QCR_CMD_RDSR1, `QCR_CMD_RDSR2: begin
                     st_nxt = ST_RDSR;
                     sh_nxt = {8'h00, srByte[6:0], srByte[7]};
                     out_nxt = {2'b00, srByte[7], 1'b0};
                     oe_nxt = 4'h2;
                  end
                  `QCR_CMD_WRSR: st_nxt = ST_WSR;
                  `QCR_CMD_QIOR: st_nxt = qe_r ? ST_ADDR : ST_IGN;
                  default: st_nxt = ST_IGN;
               endcase
            end
         end
         ST_WSR: begin
            sh_nxt = {sh_r[14:0], linkDqIn[0]};
            if (cnt_r == `QCR_WSR_LAST) begin
               // second byte bit one sets or clears
               qe_nxt = sh_r[0];
               st_nxt = ST_IGN;
            end
         end
         ST_RDSR: begin
            // byte repeats for as long as the host clocks
            out_nxt[1] = sh_r[7];
            sh_nxt[7:0] = {sh_r[6:0], sh_r[7]};
         end
         ST_ADDR: begin
            dat_nxt = {dat_r[3:0], linkDqIn};
            if (cnt_r == `QCR_ADDR_LAST) begin
               st_nxt = ST_MODE;
               cnt_nxt = 5'h00;
            end
         end
         ST_MODE: begin
            sh_nxt[3:0] = linkDqIn;
            if (cnt_r == `QCR_MODE_LAST) begin
               st_nxt = ST_DUMMY;
               cnt_nxt = 5'h00;
               // enter on A5h with flag set
               // 00h (or any other) leaves after read
               cont_nxt = (modeByte == `QCR_MODE_ENTER) && qe_r;
            end
         end
         ST_DUMMY: begin
            if (cnt_r == `QCR_DUMMY_LAST) begin
               st_nxt = ST_DATA;
               cnt_nxt = 5'h00;
               out_nxt = dat_r[7:4];
               oe_nxt = 4'hf;
            end
         end
         ST_DATA: begin
            // data is the address low byte, counting up
            if (!cnt_r[0]) begin
               out_nxt = dat_r[3:0];
            end else begin
               dat_nxt = 8'(dat_r + 8'h01);
               out_nxt = dat_nxt[7:4];
            end
         end
         ST_IGN: cnt_nxt = cnt_r;
         default: st_nxt = ST_IGN;
      endcase
      if (ones_r < `QCR_ONES_CLKS) begin
         if (linkDqIn == `QCR_NIB_ONES) begin
            ones_nxt = 4'(ones_r + 4'h1);
            if (ones_nxt == `QCR_ONES_CLKS) begin
               cont_nxt = 1'b0;
            end
         end else begin
            ones_nxt = `QCR_ONES_DEAD;
         end
      end
   end

   // per-frame state, cleared whenever chip select is high
   always_ff @(posedge linkClk or posedge frameRst) begin
      if (frameRst) begin
         st_r <= ST_FIRST;
         cnt_r <= 5'h00;
         sh_r <= 16'h0000;
         dat_r <= 8'h00;
         ones_r <= 4'h0;
         out_r <= 4'h0;
         oe_r <= 4'h0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         dat_r <= dat_nxt;
         ones_r <= ones_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
      end
   end

   // flags that outlive a frame
   always_ff @(posedge linkClk or posedge rstLink_r) begin
      if (rstLink_r) begin
         qe_r <= 1'b0;
         cont_r <= 1'b0;
      end else begin
         qe_r <= qe_nxt;
         cont_r <= cont_nxt;
      end
   end

   assign linkDqOut = out_r;
   assign linkDqOe = oe_r;

   // ---------------- checks ----------------
   a_sfdp_top_byte: assert property (@(posedge ref_clk) disable iff (reset)
      (avsRead && wait_r && regSel(avsAddress) == SEL_SFDP)
      |=> (!wait_r && rd_r[31:24] == 8'hff))
      else $error("parameter top byte not all ones");
   a_sfdp_hold_bit: assert property (@(posedge ref_clk) disable iff (reset)
      (avsRead && wait_r && regSel(avsAddress) == SEL_SFDP) |=> !rd_r[23])
      else $error("hold disable bit not zero");
   a_sfdp_exit_field: assert property (@(posedge ref_clk) disable iff (reset)
      (avsRead && wait_r && regSel(avsAddress) == SEL_SFDP)
      |=> (rd_r[15:10] == 6'h3d && rd_r[22:16] == 7'h59))
      else $error("exit or enable field wrong");
   a_sfdp_quad_bit: assert property (@(posedge ref_clk) disable iff (reset)
      (avsRead && wait_r && regSel(avsAddress) == SEL_SFDP) |=> rd_r[9])
      else $error("continuous read support bit not one");
   a_sfdp_low_bits: assert property (@(posedge ref_clk) disable iff (reset)
      (avsRead && wait_r && regSel(avsAddress) == SEL_SFDP) |=> (rd_r[8:0] == 9'h000))
      else $error("all-quad disable bits not zero");
   a_sr2_flag_out: assert property (@(posedge linkClk) disable iff (frameRst)
      (st_r == ST_CMD && cnt_r == 5'h07 && cmdByte == 8'h35)
      |=> oe_r[1] ##6 (out_r[1] == qe_r))
      else $error("status two bit one does not show the flag");
   a_wsr_sets_qe: assert property (@(posedge linkClk) disable iff (rstLink_r)
      (st_r == ST_WSR && cnt_r == 5'h0f) |-> (st_nxt == ST_IGN) ##1 (qe_r == $past(sh_r[0])))
      else $error("write status did not update the flag");
   a_mode_enter: assert property (@(posedge linkClk) disable iff (frameRst)
      (st_r == ST_MODE && cnt_r == 5'h01 && modeByte == 8'ha5 && qe_r) |=> cont_r)
      else $error("mode bits A5h did not enter continuous mode");
   a_mode_exit: assert property (@(posedge linkClk) disable iff (frameRst)
      (st_r == ST_MODE && cnt_r == 5'h01 && modeByte == 8'h00) |=> !cont_r)
      else $error("mode bits 00h did not leave continuous mode");
   a_ones_exit: assert property (@(posedge linkClk) disable iff (rstLink_r)
      (ones_r == 4'h7 && linkDqIn == 4'hf) |=> !cont_r)
      else $error("eight all-ones clocks did not leave continuous mode");
   a_cont_address: assert property (@(posedge linkClk) disable iff (frameRst)
      (st_r == ST_FIRST && linkEnS && cont_r) |=> (st_r == ST_ADDR && cnt_r == 5'h01))
      else $error("continuous frame did not start in address phase");
endmodule

// [test/qcr_host_model.sv]
// host-side serial flash controller model that drives the link
module qcr_host_model (
   output logic linkClk,
   output logic linkCsN,
   output qcr_pkg::qcr_nib_t hostDq,
   input wire qcr_pkg::qcr_nib_t linkDqOut,
   input wire qcr_pkg::qcr_nib_t linkDqOe
);
   timeunit 1ns;
   timeprecision 100ps;
   import qcr_pkg::*;
   qcr_nib_t seenDq; // device nibble standing before the last rise
   qcr_nib_t oeAll; // every enable seen in this frame
   logic [7:0] statusVal; // last status byte read
   logic [31:0] readWord; // last four data bytes read
   // clock parked low and select high between frames
   initial begin
      linkClk = 1'b0;
      linkCsN = 1'b1;
      hostDq = 4'h5;
   end
   // one 12 ns clock: lines set while low, device sampled just before the rise
   task automatic cycle(input qcr_nib_t nib);
      hostDq = nib;
      #6;
      seenDq = linkDqOut;
      oeAll = oeAll | linkDqOe;
      linkClk = 1'b1;
      #6;
      linkClk = 1'b0;
   endtask
   // select low, enable history cleared
   task automatic open_frame;
      oeAll = 4'h0;
      linkCsN = 1'b0;
      #6;
   endtask
   // released lines flip so a stale level never passes for data
   task automatic close_frame;
      oeAll = oeAll | linkDqOe;
      linkCsN = 1'b1;
      hostDq = ~hostDq;
      #40;
   endtask
   // one byte on line 0, msb first; idle lines keep toggling
   task automatic serial_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         cycle({~hostDq[3:1], b[i]});
      end
   endtask
   // status byte back on line 1
   task automatic read_status(input logic [7:0] cmd);
      open_frame();
      serial_byte(cmd);
      for (int i = 7; i >= 0; i--) begin
         cycle(~hostDq);
         statusVal[i] = seenDq[1];
      end
      close_frame();
   endtask
   task automatic write_status(input logic [7:0] b1, input logic [7:0] b2);
      open_frame();
      serial_byte(8'h01);
      serial_byte(b1);
      serial_byte(b2);
      close_frame();
   endtask
   // quad read, instruction only outside continuous mode
   task automatic quad_read(input logic withCmd, input logic [23:0] addr, input logic [7:0] mode);
      open_frame();
      if (withCmd) begin
         serial_byte(8'heb);
      end
      for (int i = 5; i >= 0; i--) begin
         cycle(addr[i*4 +: 4]);
      end
      cycle(mode[7:4]);
      cycle(mode[3:0]);
      repeat (4) cycle(~hostDq);
      for (int i = 7; i >= 0; i--) begin
         cycle(~hostDq);
         readWord[i*4 +: 4] = seenDq;
      end
      close_frame();
   endtask
   // mode bit reset by eight all-ones clocks
   task automatic ones_reset;
      open_frame();
      repeat (8) cycle(4'hf);
      close_frame();
   endtask
endmodule

// [test/tb_quad_continuous_read_control.sv]
// self-checking bench for the quad continuous read control block
module tb_quad_continuous_read_control;
   timeunit 1ns;
   timeprecision 100ps;
   import qcr_pkg::*;
`define TB_CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
   logic ref_clk, reset, avsRead, avsWrite, avsWaitrequest, linkClk, linkCsN;
   logic [3:0] avsAddress, avsByteenable;
   logic [31:0] avsWritedata, avsReaddata, d;
   qcr_nib_t hostDq, dqLine, linkDqOut, linkDqOe;
   int bad_count = 0;
   int total_checks = 0;
   logic qeRef = 1'b0; // reference flag state
   logic contRef = 1'b0; // reference continuous state
   logic enRef = 1'b1; // reference link enable
   logic [7:0] rnd = 8'h54; // lfsr state, seed 84
   // wire level: device where it drives, host elsewhere
   assign dqLine = (linkDqOe & linkDqOut) | (~linkDqOe & hostDq);
   qcr_top dut (.ref_clk(ref_clk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
      .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .linkClk(linkClk),
      .linkCsN(linkCsN), .linkDqIn(dqLine), .linkDqOut(linkDqOut), .linkDqOe(linkDqOe));
   qcr_host_model host (.linkClk(linkClk), .linkCsN(linkCsN), .hostDq(hostDq),
      .linkDqOut(linkDqOut), .linkDqOe(linkDqOe));
   // 40 MHz bus clock
   always #12.5 ref_clk = ~ref_clk;
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // bus read: request held until waitrequest is seen low
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] q);
      @(posedge ref_clk);
      avsAddress <= a;
      avsRead <= 1'b1;
      @(posedge ref_clk);
      // only the watchdog ends this wait
      while (avsWaitrequest !== 1'b0) begin
         @(posedge ref_clk);
      end
      q = avsReaddata;
      avsRead <= 1'b0;
   endtask
   // bus write: takes effect at the edge seeing waitrequest low
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] be);
      @(posedge ref_clk);
      avsAddress <= a;
      avsWritedata <= v;
      avsByteenable <= be;
      avsWrite <= 1'b1;
      @(posedge ref_clk);
      // only the watchdog ends this wait
      while (avsWaitrequest !== 1'b0) begin
         @(posedge ref_clk);
      end
      avsWrite <= 1'b0;
   endtask
   // status word crosses a synchroniser, so let it settle first
   task automatic status_check;
      logic [31:0] q;
      repeat (4) @(posedge ref_clk);
      bus_rd(4'h4, q);
      `TB_CHK("status word", {30'h0, contRef, qeRef}, q)
   endtask
   // quad read against the reference; refused frames must never drive
   task automatic qread(input logic withCmd, input logic [7:0] mode);
      logic [7:0] a;
      logic take;
      logic [7:0] e;
      logic [7:0] expQ[$];
      rnd = lfsr_next(rnd);
      a = rnd;
      take = enRef & qeRef;
      host.quad_read(withCmd, {16'h0, a}, mode);
      `TB_CHK("read drive", take ? 4'hf : 4'h0, host.oeAll)
      if (take) begin
         // reference bytes: address low byte counting up
         for (int k = 0; k < 4; k++) begin
            expQ.push_back(8'(a + k));
         end
         for (int k = 3; k >= 0; k--) begin
            e = expQ.pop_front();
            `TB_CHK("read byte", e, host.readWord[k*8 +: 8])
         end
         contRef = (mode == 8'ha5);
      end
      status_check();
   endtask
   // status byte two, flag at bit one, only line 1 driven
   task automatic qe_check;
      host.read_status(8'h35);
      `TB_CHK("flag bit", qeRef, host.statusVal[1])
      `TB_CHK("status drive", 4'h2, host.oeAll)
   endtask
   task automatic results;
      if (bad_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // hang guard, far beyond the expected run
   initial begin
      #400000;
      bad_count++;
      results();
   end
   initial begin
      ref_clk = 1'b0;
      reset = 1'b1;
      avsAddress = 4'h0;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWritedata = 32'h0;
      avsByteenable = 4'hf;
      // three edges; the synchronisers clear asynchronously anyway
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      bus_rd(4'h0, d);
      `TB_CHK("rfu top", 8'hff, d[31:24])
      `TB_CHK("hold wp", 1'b0, d[23])
      `TB_CHK("qe code", 3'h5, d[22:20])
      `TB_CHK("entry", 4'h9, d[19:16])
      `TB_CHK("exit", 6'h3d, d[15:10])
      `TB_CHK("quad sup", 1'b1, d[9])
      `TB_CHK("no qpi", 9'h000, d[8:0])
      // read-only dword ignores writes; unmapped reads give zero
      rnd = lfsr_next(rnd);
      bus_wr(4'h0, {24'h0, rnd}, 4'hf);
      bus_rd(4'h0, d);
      `TB_CHK("dword", 32'hff59f600, d)
      bus_rd(4'hc, d);
      `TB_CHK("unmapped", 32'h0, d)
      status_check();
      host.read_status(8'h05);
      `TB_CHK("status one", 8'h00, host.statusVal)
      qe_check();
      qread(1'b1, 8'ha5);
      host.write_status(8'h00, 8'h02);
      qeRef = 1'b1;
      qe_check();
      qread(1'b1, 8'ha5);
      qread(1'b0, 8'ha5);
      qread(1'b0, 8'h00);
      qread(1'b1, 8'h00);
      qread(1'b1, 8'ha5);
      host.ones_reset();
      contRef = 1'b0;
      status_check();
      qread(1'b1, 8'h00);
      // enable write without lane zero has no effect
      bus_wr(4'h8, 32'h0, 4'he);
      bus_rd(4'h8, d);
      `TB_CHK("ctrl lane", 32'h1, d)
      bus_wr(4'h8, 32'h0, 4'hf);
      enRef = 1'b0;
      host.read_status(8'h05);
      qread(1'b1, 8'h00);
      bus_wr(4'h8, 32'h1, 4'hf);
      enRef = 1'b1;
      host.read_status(8'h05);
      qread(1'b1, 8'h00);
      host.write_status(8'h00, 8'h00);
      qeRef = 1'b0;
      qe_check();
      qread(1'b1, 8'ha5);
      results();
   end
endmodule
